/* File: logic/mrcp_pkg.sv */
// Constants and carrier types for the mask ROM code protection block
//
// Behaviour
// - The 64-byte key array reads as all ones until a byte of it is written.
// - With no protect bit set verify works, encrypted once the key is set.
// - Protect bit one stops external table reads from seeing internal ROM.
// - Protect bit one makes the external access select the reset-time value.
// - Protect bit one refuses every further write into the image.
// - Protect bit two blocks the verify read-out of user ROM.
// - Only the listed protect bit combinations have a defined behaviour.
package mrcp_pkg;

   // ----------------------------------------
   // Image layout
   // ----------------------------------------
   localparam logic [12:0] ROM_BASE = 13'h0000;
   localparam logic [12:0] ROM_LAST = 13'h0FFF;
   localparam logic [12:0] KEY_BASE = 13'h1000;
   localparam logic [12:0] KEY_LAST = 13'h103F;
   localparam logic [12:0] OPT_ADDR = 13'h1040;
   localparam int OPT_BIT_ONE = 0;
   localparam int OPT_BIT_TWO = 1;
   localparam int KEY_BYTES = 64;
   localparam int ROM_BYTES = 4096;

   // ----------------------------------------
   // Reset values and fixed answers
   // ----------------------------------------
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] OPT_RESET = 8'hFF;
   localparam logic [7:0] BLANK_BYTE = 8'hFF;
   localparam logic [1:0] SEL_SETTLE = 2'h2;

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_CLEAR = 4'h1;
   localparam logic [3:0] REG_OPTION = 4'h2;
   localparam int ST_PROT_ONE = 0;
   localparam int ST_PROT_TWO = 1;
   localparam int ST_KEY_SET = 2;
   localparam int ST_SEL_HELD = 3;
   localparam int ST_REFUSED = 4;
   localparam int ST_UNDEF = 5;

   // Block state apart from the ROM array
   typedef struct packed {
      logic [KEY_BYTES-1:0][7:0] keyArr;
      logic [7:0] optByte;
      logic keySet;
      logic refused;
      logic syncA;
      logic syncB;
      logic [1:0] settleCnt;
      logic latchDone;
      logic selHeld;
      logic [7:0] rdData;
      logic [7:0] verifyData;
      logic verifyValid;
      logic [7:0] fetchData;
      logic fetchValid;
      logic fetchBlocked;
   } mrcp_state_t;

endpackage

/* File: logic/mrcp_protect.sv */
// Mask ROM code protection: image store, verify, fetch and lock logic
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module mrcp_protect
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic progWrite,
   input wire logic [12:0] progAddr,
   input wire logic [7:0] progData,
   input wire logic verifyReq,
   input wire logic [11:0] verifyAddr,
   output logic [7:0] verifyData,
   output logic verifyValid,
   input wire logic fetchReq,
   input wire logic [11:0] fetchAddr,
   input wire logic fetchTableRead,
   input wire logic fetchFromExternal,
   output logic [7:0] fetchData,
   output logic fetchValid,
   output logic fetchBlocked,
   input wire logic extAccessPin,
   output logic extAccessSelect,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData
);

   // ----------------------------------------
   // State and storage
   // ----------------------------------------
   mrcp_pkg::mrcp_state_t stateReg;
   mrcp_pkg::mrcp_state_t stateNext;
   logic [7:0] romMem [0:mrcp_pkg::ROM_BYTES-1];

   logic protOne;
   logic protTwo;
   logic undefCombo;
   logic verifyBlock;
   logic encOn;
   logic romWe;
   logic isRom;
   logic isKey;
   logic isOpt;
   logic [7:0] romByteV;
   logic [7:0] keyByteV;
   logic [7:0] romByteF;
   logic fetchDeny;
   logic writeTry;
   logic [7:0] statusVal;

   // Protect bits are programmed when the option bit reads zero
   assign protOne = ~stateReg.optByte[mrcp_pkg::OPT_BIT_ONE];
   assign protTwo = ~stateReg.optByte[mrcp_pkg::OPT_BIT_TWO];
   // Bit two without bit one: external table reads and verify blocked, writes and select left open
   assign undefCombo = protTwo & ~protOne;
   assign verifyBlock = protTwo;
   assign encOn = stateReg.keySet;

   // Image address decode
   assign isRom = progAddr <= mrcp_pkg::ROM_LAST;
   assign isKey = (progAddr >= mrcp_pkg::KEY_BASE) &&
                  (progAddr <= mrcp_pkg::KEY_LAST);
   assign isOpt = progAddr == mrcp_pkg::OPT_ADDR;
   // Writes are refused once protect bit one is set
   assign writeTry = progWrite & (isRom | isKey | isOpt);
   assign romWe = writeTry & isRom & ~protOne;

   // Array read ports
   assign romByteV = romMem[verifyAddr];
   assign keyByteV = stateReg.keyArr[verifyAddr[5:0]];
   assign romByteF = romMem[fetchAddr];
   // External table reads may not see internal code while either protect bit is set
   assign fetchDeny = fetchTableRead & fetchFromExternal &
                      (protOne | undefCombo);

   // Status word
   always_comb
   begin
      statusVal = 8'h00;
      statusVal[mrcp_pkg::ST_PROT_ONE] = protOne;
      statusVal[mrcp_pkg::ST_PROT_TWO] = protTwo;
      statusVal[mrcp_pkg::ST_KEY_SET] = stateReg.keySet;
      statusVal[mrcp_pkg::ST_SEL_HELD] = stateReg.selHeld;
      statusVal[mrcp_pkg::ST_REFUSED] = stateReg.refused;
      statusVal[mrcp_pkg::ST_UNDEF] = undefCombo;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      stateNext = stateReg;
      // Pin synchroniser
      stateNext.syncA = extAccessPin;
      stateNext.syncB = stateReg.syncA;
      // Catch the select once the synchroniser has filled after reset
      if (!stateReg.latchDone)
      begin
         if (stateReg.settleCnt == mrcp_pkg::SEL_SETTLE)
         begin
            stateNext.selHeld = stateReg.syncB;
            stateNext.latchDone = 1'b1;
         end
         else
         begin
            stateNext.settleCnt = stateReg.settleCnt + 2'h1;
         end
      end
      // Key and option writes while the image is open
      if (progWrite && !protOne)
      begin
         if (isKey)
         begin
            stateNext.keyArr[progAddr[5:0]] = progData;
            if (progData != mrcp_pkg::ERASED_BYTE)
            begin
               stateNext.keySet = 1'b1;
            end
         end
         if (isOpt)
         begin
            stateNext.optByte = progData;
         end
      end
      // Refused flag: software clear, a refusal in the same cycle wins
      if (regWrite && regAddr == mrcp_pkg::REG_CLEAR &&
          regWrData[mrcp_pkg::ST_REFUSED])
      begin
         stateNext.refused = 1'b0;
      end
      if (writeTry && protOne)
      begin
         stateNext.refused = 1'b1;
      end
      // Verify read-out
      stateNext.verifyValid = verifyReq;
      stateNext.verifyData = stateReg.verifyData;
      if (verifyReq)
      begin
         if (verifyBlock)
         begin
            stateNext.verifyData = mrcp_pkg::BLANK_BYTE;
         end
         else if (encOn)
         begin
            stateNext.verifyData = romByteV ^ keyByteV;
         end
         else
         begin
            stateNext.verifyData = romByteV;
         end
      end
      // Code fetch
      stateNext.fetchValid = fetchReq;
      stateNext.fetchBlocked = fetchReq & fetchDeny;
      if (fetchReq)
      begin
         stateNext.fetchData = fetchDeny ? mrcp_pkg::BLANK_BYTE
                                         : romByteF;
      end
      // Register read data stands in the next cycle only
      stateNext.rdData = 8'h00;
      if (regRead)
      begin
         unique case (regAddr)
            mrcp_pkg::REG_STATUS: stateNext.rdData = statusVal;
            mrcp_pkg::REG_OPTION: stateNext.rdData = stateReg.optByte;
            default: stateNext.rdData = 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stateReg <= '0;
         stateReg.keyArr <= {mrcp_pkg::KEY_BYTES{mrcp_pkg::ERASED_BYTE}};
         stateReg.optByte <= mrcp_pkg::OPT_RESET;
         stateReg.verifyData <= mrcp_pkg::BLANK_BYTE;
         stateReg.fetchData <= mrcp_pkg::BLANK_BYTE;
      end
      else
      begin
         stateReg <= stateNext;
      end
   end

   // ROM array write port, no reset
   always_ff @(posedge core_clk)
   begin
      if (romWe)
      begin
         romMem[progAddr[11:0]] <= progData;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign verifyData = stateReg.verifyData;
   assign verifyValid = stateReg.verifyValid;
   assign fetchData = stateReg.fetchData;
   assign fetchValid = stateReg.fetchValid;
   assign fetchBlocked = stateReg.fetchBlocked;
   assign regRdData = stateReg.rdData;
   // Locked parts use the reset-time select
   assign extAccessSelect = protOne ? stateReg.selHeld
                                    : stateReg.syncB;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_key_erased: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       !stateReg.keySet |->
       stateReg.keyArr == {mrcp_pkg::KEY_BYTES{mrcp_pkg::ERASED_BYTE}})
      else $error("key not all ones while unset");

   a_verify_plain: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       verifyReq && !protTwo && !encOn |=>
       verifyValid && verifyData == $past(romByteV))
      else $error("plain verify byte wrong");

   a_verify_cipher: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       verifyReq && !protTwo && encOn |=>
       verifyData == ($past(romByteV) ^ $past(keyByteV)))
      else $error("encrypted verify byte wrong");

   a_fetch_denied: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       fetchReq && fetchTableRead && fetchFromExternal && protOne |=>
       fetchBlocked && fetchData == mrcp_pkg::BLANK_BYTE)
      else $error("external table read saw internal code");

   a_select_held: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       protOne && $past(protOne) && stateReg.latchDone &&
       $past(stateReg.latchDone) |->
       $stable(extAccessSelect))
      else $error("locked select followed the pin");

   a_write_refused: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       writeTry && protOne |-> !romWe ##1
       (stateReg.refused && $stable(stateReg.optByte) &&
        $stable(stateReg.keyArr)))
      else $error("write accepted while locked");

   a_verify_blocked: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       verifyReq && protTwo |=>
       verifyValid && verifyData == mrcp_pkg::BLANK_BYTE)
      else $error("verify not blocked");

   a_undef_locked: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       fetchReq && fetchTableRead && fetchFromExternal && undefCombo |=>
       fetchBlocked)
      else $error("undefined combination left table reads open");

   a_fetch_open: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       fetchReq && !(fetchTableRead && fetchFromExternal) |=>
       fetchValid && !fetchBlocked && fetchData == $past(romByteF))
      else $error("internal fetch refused");

   a_fetch_pulse: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       !fetchReq |=> !fetchValid && !fetchBlocked)
      else $error("fetch answer without request");

   a_key_marks: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       progWrite && isKey && !protOne &&
       progData != mrcp_pkg::ERASED_BYTE |=> stateReg.keySet)
      else $error("key write did not mark the key set");

   a_open_writable: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       progWrite && isOpt && !protOne |=>
       stateReg.optByte == $past(progData))
      else $error("option write lost while open");

   a_undef_shown: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       regRead && regAddr == mrcp_pkg::REG_STATUS |=>
       regRdData[mrcp_pkg::ST_UNDEF] == $past(undefCombo))
      else $error("status hides undefined combination");

   a_read_once: assert property
      (@(posedge core_clk) disable iff (!reset_n)
       !regRead |=> regRdData == 8'h00)
      else $error("read data outside its cycle");

endmodule

/* File: sim/mrcp_supplier.sv */
// Image supplier model: writes ROM, key or option bytes into the block
`timescale 1ns/1ps
module mrcp_supplier
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic go,
   input wire logic [1:0] mode,
   input wire logic [7:0] val,
   input wire logic rogue,
   output logic progWrite,
   output logic [12:0] progAddr,
   output logic [7:0] progData,
   output logic busy
);
   logic [6:0] idx;
   // One byte a cycle while busy; released lines invert every cycle
   always @(posedge core_clk or negedge reset_n)
      if (!reset_n)
         {progWrite, busy, idx, progAddr, progData} <= '0;
      else
      begin
         progWrite <= busy;
         idx <= busy ? idx + 7'h01 : 7'h00;
         busy <= busy ? (idx != (mode == 2'h2 ? 7'h00 : 7'h3F)) : go;
         if (busy)
            case (mode)
               2'h0:
               begin
                  progAddr <= {7'h00, idx[5:0]};
                  progData <= {2'h0, idx[5:0]} ^ val;
               end
               2'h1:
               begin
                  progAddr <= mrcp_pkg::KEY_BASE | {7'h00, idx[5:0]};
                  progData <= {2'h0, idx[5:0]} * 8'h03 + 8'h01;
               end
               default:
               begin
                  progAddr <= mrcp_pkg::OPT_ADDR;
                  progData <= rogue ? val
                     : {val[7:2], val[1] | val[0], val[0]};
               end
            endcase
         else
         begin
            progAddr <= ~progAddr;
            progData <= ~progData;
         end
      end
endmodule

/* File: sim/tb_mrcp_protect.sv */
// Testbench for the mask ROM code protection block
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_mrcp_protect;
   logic core_clk, reset_n, go, rogue, busy, rdPend, extAccessPin;
   logic verifyReq, fetchReq, fetchTableRead, fetchFromExternal;
   logic regWrite, regRead, progWrite, verifyValid, fetchValid;
   logic fetchBlocked, extAccessSelect;
   logic [1:0] mode;
   logic [7:0] val, regWrData, regRdData, verifyData, fetchData, progData;
   logic [11:0] verifyAddr, fetchAddr, a;
   logic [12:0] progAddr;
   logic [3:0] regAddr;
   logic [8:0] got, want;
   logic [8:0] expQ[$];
   int failures, n_checks, cycles, seed;

   mrcp_supplier sup_u (.core_clk(core_clk), .reset_n(reset_n), .go(go),
      .mode(mode), .val(val), .rogue(rogue), .progWrite(progWrite),
      .progAddr(progAddr), .progData(progData), .busy(busy));
   mrcp_protect dut_u (.core_clk(core_clk), .reset_n(reset_n),
      .progWrite(progWrite), .progAddr(progAddr), .progData(progData),
      .verifyReq(verifyReq), .verifyAddr(verifyAddr),
      .verifyData(verifyData), .verifyValid(verifyValid),
      .fetchReq(fetchReq), .fetchAddr(fetchAddr),
      .fetchTableRead(fetchTableRead),
      .fetchFromExternal(fetchFromExternal), .fetchData(fetchData),
      .fetchValid(fetchValid), .fetchBlocked(fetchBlocked),
      .extAccessPin(extAccessPin), .extAccessSelect(extAccessSelect),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData));

   // Expected ROM byte and its encrypted form
   function automatic logic [7:0] romB(input logic [11:0] ad);
      return {2'h0, ad[5:0]} ^ 8'h5A;
   endfunction
   function automatic logic [7:0] encB(input logic [11:0] ad);
      return romB(ad) ^ ({2'h0, ad[5:0]} * 8'h03 + 8'h01);
   endfunction

   // Clock at 40 MHz
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic stop_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic rst(input logic pin);
      reset_n <= 1'b0;
      extAccessPin <= pin;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic prog(input logic [1:0] m, input logic [7:0] v,
      input logic r);
      @(posedge core_clk);
      go <= 1'b1;
      mode <= m;
      val <= v;
      rogue <= r;
      @(posedge core_clk);
      go <= 1'b0;
      do @(posedge core_clk); while (busy);
      repeat (2) @(posedge core_clk);
   endtask

   // Kind 0 read, 1 verify, 2 fetch, 3 register write
   task automatic req(input int k, input logic [11:0] ad,
      input logic [8:0] e);
      @(posedge core_clk);
      regRead <= (k == 0);
      verifyReq <= (k == 1);
      fetchReq <= (k == 2);
      regWrite <= (k == 3);
      regAddr <= ad[3:0];
      verifyAddr <= ad;
      fetchAddr <= ad;
      regWrData <= e[7:0];
      if (k < 3)
         expQ.push_back(e);
   endtask

   task automatic idle;
      req(4, 12'h000, 9'h000);
      repeat (2) @(posedge core_clk);
   endtask

   task automatic vrnd(input logic en);
      repeat (8)
      begin
         a = $random(seed) & 12'h03F;
         req(1, a, {1'b0, en ? encB(a) : romB(a)});
      end
      idle;
   endtask

   task automatic pinCheck(input logic e);
      extAccessPin <= 1'b0;
      repeat (4) @(posedge core_clk);
      `CHK(extAccessSelect, e)
      extAccessPin <= 1'b1;
   endtask

   // Result watcher: oldest expectation against each answer
   always @(posedge core_clk)
   begin
      cycles++;
      if (reset_n && (rdPend || verifyValid || fetchValid))
      begin
         got = rdPend ? {1'b0, regRdData} : verifyValid ?
            {1'b0, verifyData} : {fetchBlocked, fetchData};
         want = expQ.pop_front();
         `CHK(got, want)
      end
      rdPend = regRead;
      if (cycles == 20000)
      begin
         failures++;
         stop_test;
      end
   end

   // Main sequence
   initial
   begin
      seed = 15;
      {go, rogue, verifyReq, fetchReq, regWrite, regRead} = '0;
      {fetchTableRead, fetchFromExternal, mode, val, regWrData} = '0;
      {verifyAddr, fetchAddr, regAddr} = '0;
      {failures, n_checks} = '0;
      rst(1'b1);
      req(0, 12'h000, 9'h008);
      req(0, 12'h002, 9'h0FF);
      req(0, 12'h00F, 9'h000);
      idle;
      prog(2'h0, 8'h5A, 1'b0);
      vrnd(1'b0);
      fetchTableRead <= 1'b1;
      fetchFromExternal <= 1'b1;
      req(2, 12'h005, {1'b0, romB(12'h005)});
      idle;
      pinCheck(1'b0);
      prog(2'h1, 8'h00, 1'b0);
      vrnd(1'b1);
      prog(2'h2, 8'hFE, 1'b0);
      req(0, 12'h000, 9'h00D);
      req(2, 12'h007, 9'h1FF);
      idle;
      fetchFromExternal <= 1'b0;
      req(2, 12'h007, {1'b0, romB(12'h007)});
      req(1, 12'h009, {1'b0, encB(12'h009)});
      idle;
      pinCheck(1'b1);
      prog(2'h0, 8'h00, 1'b0);
      req(0, 12'h000, 9'h01D);
      req(1, 12'h003, {1'b0, encB(12'h003)});
      req(3, 12'h001, 9'h010);
      req(0, 12'h000, 9'h00D);
      idle;
      rst(1'b0);
      fetchFromExternal <= 1'b1;
      prog(2'h2, 8'hFD, 1'b1);
      req(0, 12'h000, 9'h022);
      req(2, 12'h004, 9'h1FF);
      idle;
      prog(2'h2, 8'hFC, 1'b0);
      req(0, 12'h000, 9'h003);
      req(1, 12'h004, 9'h0FF);
      req(2, 12'h004, 9'h1FF);
      idle;
      `CHK(expQ.size(), 0)
      stop_test;
   end
endmodule
